// File: src/cpulpm_pkg.sv
// Package for the low power mode controller: register map, fields, states.
// Assumes an 8-bit special function register bus inside the core.
package cpulpm_pkg;
  localparam logic [7:0] PMC_ADDR      = 8'h87;
  localparam logic [7:0] PMC_RESET     = 8'h00;
  localparam int         PMC_IDLE_BIT  = 0;
  localparam int         PMC_STOP_BIT  = 1;
  localparam int         PMC_FLAG_LSB  = 2;
  localparam int         FLAG_W        = 6;
  localparam logic [5:0] FLAG_RESET    = 6'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int         MCD_TIMEOUT_US = 100;
  localparam int         MCLK_MHZ       = 50;
  localparam int         MCD_CYCLES     = MCD_TIMEOUT_US * MCLK_MHZ;

  typedef enum logic [1:0] {
    CPULPM_RUN  = 2'b00,
    CPULPM_IDLE = 2'b01,
    CPULPM_STOP = 2'b11
  } cpulpm_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpulpm_sfr_s;
endpackage

// File: src/cpulpm_flags.sv
// Spare software flag storage of the power mode control register.
// Assumes writes come from the core on mclk.
`timescale 1ns/10ps
`default_nettype none
module cpulpm_flags
  import cpulpm_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n_sync,
  input  wire logic              we,
  input  wire logic [FLAG_W-1:0] wdata,
  output logic      [FLAG_W-1:0] rdata
);
  logic [FLAG_W-1:0] flags_ff;
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) flags_ff <= FLAG_RESET;
    else if (we) flags_ff <= wdata;
  end
  assign rdata = flags_ff;
endmodule
`default_nettype wire

// File: src/cpulpm_ctrl.sv
// Low power mode controller: idle and stop selection, wake and reset.
// Assumes the core drives sfr with single-cycle strobes and reports instruction end.
`timescale 1ns/10ps
`default_nettype none
module cpulpm_ctrl
  import cpulpm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire cpulpm_sfr_s sfr,
  input  wire logic        instr_done,
  input  wire logic        irq_enabled_pending,
  input  wire logic        wdt_enable,
  input  wire logic        wdt_timeout,
  input  wire logic        mcd_enable,
  input  wire logic        mclk_missing,
  output logic [7:0]       sfr_rdata,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             int_osc_en,
  output logic             irq_logic_en,
  output logic             mcd_active,
  output logic             internal_reset,
  output logic [15:0]      fetch_addr_reset,
  output logic             mode_idle,
  output logic             mode_stop
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous event inputs, two stages
  logic [2:0] evt_meta_ff;
  logic [2:0] evt_sync_ff;
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      evt_meta_ff <= 3'h0;
      evt_sync_ff <= 3'h0;
    end else begin
      evt_meta_ff <= {mclk_missing, wdt_timeout, irq_enabled_pending};
      evt_sync_ff <= evt_meta_ff;
    end
  end
  wire irq_s  = evt_sync_ff[0];
  wire wdt_s  = evt_sync_ff[1];
  wire miss_s = evt_sync_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire pmc_wr   = sfr.wr && (sfr.addr == PMC_ADDR);
  wire pmc_rd   = sfr.rd && (sfr.addr == PMC_ADDR);
  wire set_stop = pmc_wr && sfr.wdata[PMC_STOP_BIT];
  wire set_idle = pmc_wr && sfr.wdata[PMC_IDLE_BIT];
  logic [FLAG_W-1:0] flags;

  cpulpm_flags u_flags (
    .mclk       (mclk),
    .rst_n_sync (rst_sync_ff),
    .we         (pmc_wr),
    .wdata      (sfr.wdata[7:PMC_FLAG_LSB]),
    .rdata      (flags)
  );

  wire [7:0] nxt_rdata = pmc_rd ? {flags, 2'b00} : 8'h00;
  logic [7:0] rdata_ff;
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) rdata_ff <= PMC_RESET;
    else rdata_ff <= nxt_rdata;
  end
  assign sfr_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pending request held until the writing instruction ends
  logic idle_req_ff;
  logic stop_req_ff;
  logic int_rst_ff;
  logic mcd_hit;
  wire  req_stop = set_stop || stop_req_ff;
  wire  req_idle = set_idle || idle_req_ff;
  // An internal reset drops a request still waiting for its instruction end
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      idle_req_ff <= 1'b0;
      stop_req_ff <= 1'b0;
    end else begin
      idle_req_ff <= req_idle && !instr_done && !int_rst_ff;
      stop_req_ff <= req_stop && !instr_done && !int_rst_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine
  cpulpm_mode_e mode_ff;
  cpulpm_mode_e nxt_mode;
  wire wake_reset = (wdt_enable && wdt_s) || (mcd_enable && mcd_hit);
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      CPULPM_RUN: begin
        if (instr_done && req_stop) nxt_mode = CPULPM_STOP;
        else if (instr_done && req_idle) nxt_mode = CPULPM_IDLE;
      end
      CPULPM_IDLE: begin
        if (irq_s) nxt_mode = CPULPM_RUN;
      end
      CPULPM_STOP: nxt_mode = CPULPM_STOP;
      default: nxt_mode = CPULPM_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) mode_ff <= CPULPM_RUN;
    else if (int_rst_ff) mode_ff <= CPULPM_RUN;
    else mode_ff <= nxt_mode;
  end

  // Watchdog or detector, when enabled, cause an internal reset in any mode
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) int_rst_ff <= 1'b0;
    else int_rst_ff <= wake_reset && !int_rst_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Missing clock detector: clock absent longer than the timeout
  localparam logic [12:0] MCD_LIMIT = 13'(MCD_CYCLES - 1);
  logic [12:0] mcd_cnt_ff;
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) mcd_cnt_ff <= 13'h0000;
    else if (!miss_s) mcd_cnt_ff <= 13'h0000;
    else if (mcd_cnt_ff != MCD_LIMIT) mcd_cnt_ff <= mcd_cnt_ff + 13'h0001;
  end
  assign mcd_hit = miss_s && (mcd_cnt_ff == MCD_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and enable outputs
  assign mode_idle        = (mode_ff == CPULPM_IDLE);
  assign mode_stop        = (mode_ff == CPULPM_STOP);
  assign cpu_clk_en       = (mode_ff == CPULPM_RUN);
  assign periph_clk_en    = !mode_stop;
  assign int_osc_en       = !mode_stop;
  assign irq_logic_en     = !mode_stop;
  assign mcd_active       = mcd_enable;
  assign internal_reset   = int_rst_ff;
  assign fetch_addr_reset = RESET_VECTOR;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_idle_entry;
    (mode_ff == CPULPM_RUN) && instr_done && req_idle && !req_stop && !int_rst_ff;
  endsequence
  property p_idle_entry;
    @(posedge mclk) disable iff (!rst_sync_ff) s_idle_entry |=> mode_idle && !cpu_clk_en;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_no_early;
    @(posedge mclk) disable iff (!rst_sync_ff) (mode_ff == CPULPM_RUN) && !instr_done |=> !mode_stop;
  endproperty
  a_no_early: assert property (p_no_early) else $error("stop before instruction end");

  property p_idle_periph;
    @(posedge mclk) disable iff (!rst_sync_ff) mode_idle |-> periph_clk_en && int_osc_en;
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("peripheral clock off in idle");

  property p_wake;
    @(posedge mclk) disable iff (!rst_sync_ff) mode_idle && irq_s |=> cpu_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("no interrupt wake");

  property p_stop_hold;
    @(posedge mclk) disable iff (!rst_sync_ff) mode_stop && !int_rst_ff |=> mode_stop;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");

  property p_read_zero;
    @(posedge mclk) disable iff (!rst_sync_ff) pmc_rd |=> sfr_rdata[1:0] == 2'b00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("select bit read as one");

  property p_both;
    @(posedge mclk) disable iff (!rst_sync_ff)
      (mode_ff == CPULPM_RUN) && pmc_wr && sfr.wdata[1:0] == 2'b11 && instr_done && !int_rst_ff |=> mode_stop;
  endproperty
  a_both: assert property (p_both) else $error("stop not preferred");

  property p_wdt;
    @(posedge mclk) disable iff (!rst_sync_ff) wdt_enable && wdt_s && !int_rst_ff |=> internal_reset ##1 !mode_stop;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset missing");

  property p_stop_off;
    @(posedge mclk) disable iff (!rst_sync_ff) mode_stop |-> !irq_logic_en && !int_osc_en;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop left logic running");
endmodule
`default_nettype wire

// File: verification/cpulpm_bench.sv
// Testbench for the low power mode controller: register access, idle, stop and wakes.
// Assumes cpulpm_pkg and the design files are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module cpulpm_ctrl_bench
  import cpulpm_pkg::*;
;
  localparam logic [5:0] RUN_V  = 6'h0F;
  localparam logic [5:0] IDLE_V = 6'h17;
  localparam logic [5:0] STOP_V = 6'h20;
  logic        mclk;
  logic        rst_b;
  cpulpm_sfr_s sfr;
  logic        instr_done;
  logic        irq;
  logic        wdt_en;
  logic        wdt_to;
  logic        mcd_en;
  logic        missing;
  logic [7:0]  rdata;
  logic        cpu_en;
  logic        per_en;
  logic        osc_en;
  logic        irq_en;
  logic        mcd_act;
  logic        int_rst;
  logic [15:0] fetch;
  logic        m_idle;
  logic        m_stop;
  int          miscompares;
  int          checked;
  int          cycles;

  cpulpm_ctrl dut (.mclk(mclk), .rst_b(rst_b), .sfr(sfr), .instr_done(instr_done),
    .irq_enabled_pending(irq), .wdt_enable(wdt_en), .wdt_timeout(wdt_to),
    .mcd_enable(mcd_en), .mclk_missing(missing), .sfr_rdata(rdata), .cpu_clk_en(cpu_en),
    .periph_clk_en(per_en), .int_osc_en(osc_en), .irq_logic_en(irq_en),
    .mcd_active(mcd_act), .internal_reset(int_rst), .fetch_addr_reset(fetch),
    .mode_idle(m_idle), .mode_stop(m_stop));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, timeout, shared tasks
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      final_report;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic done);
    @(negedge mclk);
    sfr = '{1'b1, 1'b0, a, d};
    instr_done = done;
    @(negedge mclk);
    sfr = '0;
    instr_done = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    sfr = '0;
    chk("read data", {8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic mode(input logic [5:0] exp);
    chk("mode outputs", {10'h000, m_stop, m_idle, cpu_en, per_en, osc_en, irq_en}, {10'h000, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'b0;
    sfr = '0;
    instr_done = 1'b0;
    irq = 1'b0;
    wdt_en = 1'b0;
    wdt_to = 1'b0;
    mcd_en = 1'b0;
    missing = 1'b0;
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    mode(RUN_V);
    rd(PMC_ADDR, PMC_RESET);
    wr(PMC_ADDR, 8'hA9, 1'b0);
    repeat (3) @(negedge mclk);
    mode(RUN_V);
    instr_done = 1'b1;
    @(negedge mclk);
    instr_done = 1'b0;
    @(negedge mclk);
    mode(IDLE_V);
    rd(PMC_ADDR, 8'hA8);
    irq = 1'b1;
    for (int i = 0; i < 10 && m_idle !== 1'b0; i++) @(negedge mclk);
    irq = 1'b0;
    mode(RUN_V);
    rd(PMC_ADDR, 8'hA8);
    rd(8'h86, 8'h00);
    // Idle write issued in the same cycle as its instruction end, with nothing pending
    wr(PMC_ADDR, 8'h55, 1'b1);
    @(negedge mclk);
    mode(IDLE_V);
    wdt_en = 1'b1;
    wdt_to = 1'b1;
    for (int i = 0; i < 10 && int_rst !== 1'b1; i++) @(negedge mclk);
    chk("watchdog reset", {15'h0000, int_rst}, 16'h0001);
    wdt_to = 1'b0;
    wdt_en = 1'b0;
    @(negedge mclk);
    mode(RUN_V);
    chk("fetch address", fetch, RESET_VECTOR);
    wr(8'h86, 8'hFF, 1'b1);
    mode(RUN_V);
    rd(PMC_ADDR, 8'h54);
    wr(PMC_ADDR, 8'h03, 1'b1);
    @(negedge mclk);
    mode(STOP_V);
    irq = 1'b1;
    repeat (8) @(negedge mclk);
    mode(STOP_V);
    irq = 1'b0;
    mcd_en = 1'b1;
    missing = 1'b1;
    @(negedge mclk);
    chk("detector active", {15'h0000, mcd_act}, 16'h0001);
    for (int i = 0; i < MCD_CYCLES + 20 && int_rst !== 1'b1; i++) @(negedge mclk);
    chk("detector reset", {15'h0000, int_rst}, 16'h0001);
    missing = 1'b0;
    mcd_en = 1'b0;
    @(negedge mclk);
    mode(RUN_V);
    wr(PMC_ADDR, 8'hFE, 1'b1);
    @(negedge mclk);
    mode(STOP_V);
    rst_b = 1'b0;
    @(negedge mclk);
    mode(RUN_V);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    rd(PMC_ADDR, PMC_RESET);
    final_report;
  end
endmodule
`default_nettype wire
